// ---- core/errlog_capture.sv ----
// Capture register for one failed posted write and the logged flag.
// Assumes abort pulses and record come from PCI master logic on sys_clk.
`timescale 1ns/100ps
`include "errlog_cfg.svh"
module errlog_capture (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic abort_evt,
  input wire errlog_pkg::fail_rec_t rec_in,
  input wire logic flag_clear,
  output logic flag_q,
  output errlog_pkg::fail_rec_t rec_q
);
  logic take;
  // Held record; its initial value gives the idle command code, since the
  // command log is deliberately left out of the general reset.
  errlog_pkg::fail_rec_t hold_q = {`ZERO32, `ZERO32, `CMD_IDLE, 4'h0};
  // An error is taken only when logging is on and nothing is held.
  assign take = abort_evt && enable && !flag_q;
  // Flag sets on capture; a write of 1 clears it, set wins.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        flag_q <= 1'b1;
      end else if (flag_clear) begin
        flag_q <= 1'b0;
      end
    end
  end
  // Record loads on capture and stays frozen while flagged.
  always_ff @(posedge sys_clk) begin
    if (clk_en && take) begin
      hold_q <= rec_in;
    end
  end
  // The output comes straight from the record flip-flops.
  assign rec_q = hold_q;
endmodule : errlog_capture

// ---- core/errlog_cfg.svh ----
// Constants for the posted-write error log: offsets, field positions, reset values.
// Assumes inclusion by bare name from design files.
`ifndef ERRLOG_CFG_SVH
`define ERRLOG_CFG_SVH
// ==========================================================================
// Register byte addresses.
`define OFF_CTRL_STATUS 12'h140
`define OFF_ADDRESS 12'h144
`define OFF_DATA 12'h148
`define OFF_IRQ_STATUS 12'h14C
`define OFF_IRQ_MASK 12'h150
// ==========================================================================
// Field positions in the control and status word.
`define BIT_ENABLE 31
`define BIT_FLAG 24
`define BIT_UNLOCK 23
`define CMD_HI 7
`define CMD_LO 4
`define BE_HI 3
`define BE_LO 0
// ==========================================================================
// Reset and idle values.
`define CMD_IDLE 4'h7
`define ZERO32 32'h0000_0000
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ---- core/errlog_pkg.sv ----
// Types shared by the error log files.
// Assumes errlog_cfg.svh supplies the numeric constants.
package errlog_pkg;
  // Record of one failed posted write.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] cmd;
    logic [3:0] be_n;
  } fail_rec_t;
  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;
endpackage : errlog_pkg

// ---- core/errlog_top.sv ----
// Posted-write error log with AXI4-Lite registers and one interrupt.
// Assumes one clock, async active-low reset, abort pulses synchronous to sys_clk.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "errlog_cfg.svh"
// How it works
// - Enable bit turns capture on, reset off.
// - Target or master abort sets flag.
// - Flag reads held; write one clears.
// - Held log frozen until flag cleared.
// - Flag stalls slave channel unless unlocked.
// - Flag reaches interrupt only when enabled.
// - Command log idles at 0111, no reset.
// - Byte enables read zero unless flagged.
// - Address reads zero unless flagged.
// - Data reads zero unless flagged.
module errlog_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic target_abort,
  input wire logic master_abort,
  input wire errlog_pkg::fail_rec_t fail_rec,
  output logic slave_suspend,
  output logic irq,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================================
  // State.
  logic enable_q;
  logic unlock_q;
  logic irq_sticky_q;
  logic irq_mask_q;
  logic flag;
  logic flag_clear;
  errlog_pkg::fail_rec_t rec;
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  logic rd_status;
  logic flag_rise;
  logic flag_prev_q;
  logic [31:0] rdata_d;
  logic wr_ok;
  logic rd_ok;

  // Returns true when the address names a mapped register.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFF_CTRL_STATUS) || (a == `OFF_ADDRESS) || (a == `OFF_DATA) ||
             (a == `OFF_IRQ_STATUS) || (a == `OFF_IRQ_MASK);
  endfunction : mapped

  // ==========================================================================
  // Capture.
  errlog_capture u_capture (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .enable(enable_q),
    .abort_evt(target_abort || master_abort),
    .rec_in(fail_rec),
    .flag_clear(flag_clear),
    .flag_q(flag),
    .rec_q(rec)
  );

  // Slave channel is held off while an error is held, unless unlocked.
  assign slave_suspend = flag && !unlock_q;

  // ==========================================================================
  // Write channel: address and data accepted in either order.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ok = mapped(awaddr_q);

  // Holds the write address until the write completes.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // Holds the write data until the write completes.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      w_held_q <= 1'b0;
      wdata_q <= `ZERO32;
      wstrb_q <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response rises on the same edge as the register update.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A 1 written to the flag bit in the top byte clears the flag.
  assign flag_clear = wr_fire && (awaddr_q == `OFF_CTRL_STATUS) && wstrb_q[3] &&
                      wdata_q[`BIT_FLAG];

  // Control bits: enable in byte 3, unlock in byte 2.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
      unlock_q <= 1'b0;
    end else if (clk_en && wr_fire && (awaddr_q == `OFF_CTRL_STATUS)) begin
      if (wstrb_q[3]) begin
        enable_q <= wdata_q[`BIT_ENABLE];
      end
      if (wstrb_q[2]) begin
        unlock_q <= wdata_q[`BIT_UNLOCK];
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_q <= 1'b0;
    end else if (clk_en && wr_fire && (awaddr_q == `OFF_IRQ_MASK) && wstrb_q[0]) begin
      irq_mask_q <= wdata_q[0];
    end
  end

  // ==========================================================================
  // Interrupt: a new logged error sets a sticky bit, cleared by reading it.
  assign flag_rise = flag && !flag_prev_q && enable_q;
  assign rd_status = rd_fire && (s_axi_araddr == `OFF_IRQ_STATUS);

  // Sticky event bit; a new event wins over the read clear.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_prev_q <= 1'b0;
      irq_sticky_q <= 1'b0;
    end else if (clk_en) begin
      flag_prev_q <= flag;
      if (flag_rise) begin
        irq_sticky_q <= 1'b1;
      end else if (rd_status) begin
        irq_sticky_q <= 1'b0;
      end
    end
  end

  // Level interrupt only while logging is enabled.
  assign irq = irq_sticky_q && irq_mask_q && enable_q;

  // ==========================================================================
  // Read channel.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_ok = mapped(s_axi_araddr);

  // Read mux; logged address, data and byte enables read as zero unless the flag is set.
  always_comb begin
    rdata_d = `ZERO32;
    case (s_axi_araddr)
      `OFF_CTRL_STATUS: begin
        rdata_d[`BIT_ENABLE] = enable_q;
        rdata_d[`BIT_FLAG] = flag;
        rdata_d[`BIT_UNLOCK] = unlock_q;
        rdata_d[`CMD_HI:`CMD_LO] = rec.cmd;
        rdata_d[`BE_HI:`BE_LO] = flag ? rec.be_n : 4'h0;
      end
      `OFF_ADDRESS: rdata_d = flag ? rec.addr : `ZERO32;
      `OFF_DATA: rdata_d = flag ? rec.data : `ZERO32;
      `OFF_IRQ_STATUS: rdata_d[0] = irq_sticky_q;
      `OFF_IRQ_MASK: rdata_d[0] = irq_mask_q;
      default: rdata_d = `ZERO32;
    endcase
  end

  // Read data registered one cycle after the address is taken.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `ZERO32;
      s_axi_rresp <= `AXI_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : errlog_top

// ---- sim/errlog_asserts.sv ----
// Checker for the error log top module ports.
// Assumes one clock and binding onto errlog_top.
`timescale 1ns/100ps
// ====
// Port-level checks.
module errlog_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic target_abort,
  input wire logic master_abort,
  input wire logic slave_suspend,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read address taken while busy");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_susp;
    $rose(slave_suspend) |-> $past(target_abort || master_abort) || $past(s_axi_wvalid)
      || $past(s_axi_wvalid, 2);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend without cause");
  property p_irq;
    $rose(irq) |-> $past(target_abort || master_abort) || $past(target_abort || master_abort, 2)
      || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  property p_fall; $fell(slave_suspend) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("suspend left without write");
endmodule : errlog_asserts
bind errlog_top errlog_asserts u_chk (.sys_clk, .resetn, .target_abort, .master_abort,
  .slave_suspend, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);

// ---- sim/pci_posted_write_error_log_tb_top.sv ----
// Testbench for the posted-write error log over AXI4-Lite.
// Assumes errlog_cfg.svh offsets and a 100 MHz clock.
`timescale 1ns/100ps
`include "errlog_cfg.svh"
// ====
// Bench top.
module pci_posted_write_error_log_tb_top;
  logic sys_clk = 0, resetn = 0, clk_en = 1, go = 0, mab = 0;
  logic [3:0] dly = 0, s_axi_wstrb = 4'hF;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, slave_suspend, irq, target_abort, master_abort;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  errlog_pkg::fail_rec_t rec = '0, fail_rec, ra, rb;
  int fail_count = 0, check_count = 0;
  errlog_top uut (.sys_clk, .resetn, .clk_en, .target_abort, .master_abort, .fail_rec,
    .slave_suspend, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  pci_target_model u_tgt (.sys_clk, .go, .mab, .dly, .rec, .target_abort, .master_abort,
    .fail_rec);
  // Clock and watchdog.
  always #5 sys_clk = ~sys_clk;
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  function automatic logic [31:0] ctl(input logic e, f, u, input logic [3:0] c, b);
    return {e, 6'h00, f, u, 15'h0000, c, b};
  endfunction : ctl
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk1
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  task automatic hit(input logic m, input errlog_pkg::fail_rec_t r, input logic [3:0] w);
    @(posedge sys_clk);
    go <= 1;
    mab <= m;
    rec <= r;
    dly <= w;
    @(posedge sys_clk);
    go <= 0;
    while (!(target_abort || master_abort)) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask : hit
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Test sequence.
  initial begin
    ra = '{32'hA5A5_0F00, 32'h1234_5678, 4'h3, 4'h2};
    rb = '{32'h0BAD_F00C, 32'h8765_4321, 4'hB, 4'hC};
    repeat (4) @(posedge sys_clk);
    resetn <= 1;
    rd(`OFF_CTRL_STATUS); chk(rv, ctl(0, 0, 0, `CMD_IDLE, 0));
    rd(`OFF_ADDRESS); chk(rv, `ZERO32);
    rd(`OFF_DATA); chk(rv, `ZERO32);
    hit(0, ra, 0); rd(`OFF_CTRL_STATUS); chk(rv, ctl(0, 0, 0, `CMD_IDLE, 0));
    $display("test reset and disabled done");
    wr(`OFF_CTRL_STATUS, ctl(1, 0, 0, 0, 0)); wr(`OFF_IRQ_MASK, 32'h1);
    hit(0, ra, 3); rd(`OFF_CTRL_STATUS); chk(rv, ctl(1, 1, 0, 4'h3, 4'h2));
    chk1(slave_suspend, 1);
    chk1(irq, 1);
    rd(`OFF_ADDRESS); chk(rv, ra.addr);
    rd(`OFF_DATA); chk(rv, ra.data);
    hit(1, rb, 0); rd(`OFF_ADDRESS); chk(rv, ra.addr);
    $display("test capture and freeze done");
    wr(`OFF_CTRL_STATUS, ctl(1, 0, 1, 0, 0)); chk1(slave_suspend, 0);
    rd(`OFF_CTRL_STATUS); chk(rv, ctl(1, 1, 1, 4'h3, 4'h2));
    rd(`OFF_IRQ_STATUS); chk(rv, 32'h1);
    chk1(irq, 0);
    wr(`OFF_CTRL_STATUS, ctl(1, 1, 1, 0, 0)); rd(`OFF_CTRL_STATUS);
    chk(rv, ctl(1, 0, 1, 4'h3, 0));
    rd(`OFF_ADDRESS); chk(rv, `ZERO32);
    $display("test clear done");
    hit(1, rb, 1); rd(`OFF_DATA); chk(rv, rb.data);
    chk1(slave_suspend, 0);
    wr(`OFF_CTRL_STATUS, ctl(0, 1, 0, 0, 0)); rd(`OFF_CTRL_STATUS);
    chk(rv, ctl(0, 0, 0, 4'hB, 0));
    chk1(irq, 0);
    rd(12'h160); chk(rv, `ZERO32); chk({30'h0, rr}, {30'h0, `AXI_SLVERR});
    wr(12'h160, 32'h1); chk({30'h0, br}, {30'h0, `AXI_SLVERR});
    wr(`OFF_IRQ_MASK, 32'h0); chk({30'h0, br}, {30'h0, `AXI_OKAY});
    $display("test master abort and disable done");
    end_of_test();
  end
endmodule : pci_posted_write_error_log_tb_top

// ---- sim/pci_target_model.sv ----
// PCI target that ends posted writes with an abort.
// Assumes requests on sys_clk; the record is valid only with the pulse.
`timescale 1ns/100ps
// ====
// Abort generator.
module pci_target_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic mab,
  input wire logic [3:0] dly,
  input wire errlog_pkg::fail_rec_t rec,
  output logic target_abort,
  output logic master_abort,
  output errlog_pkg::fail_rec_t fail_rec
);
  logic [4:0] cnt_q = 5'h00;
  errlog_pkg::fail_rec_t last_q = '0;
  // Counts down the wait, pulses one abort, then shows a changed record.
  always_ff @(posedge sys_clk) begin
    fail_rec <= ~last_q;
    target_abort <= 1'b0;
    master_abort <= 1'b0;
    if (go) begin
      cnt_q <= {1'b0, dly} + 5'h01;
      last_q <= rec;
    end else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    if (cnt_q == 5'h01) begin
      target_abort <= !mab;
      master_abort <= mab;
      fail_rec <= last_q;
    end
  end
endmodule : pci_target_model
